// ---- verilog/crafr_pkg.sv ----
// Shared constants and carrier types for the CAN register access framer
package crafr_pkg;
    localparam logic [15:0] CRAFR_ERR_REG      = 16'hffff;
    localparam logic [15:0] CRAFR_MAX_REG      = 16'hfffe;
    localparam logic [7:0]  CRAFR_SINGLE_CNT   = 8'h01;
    localparam logic [7:0]  CRAFR_MULTI_MIN    = 8'h02;
    localparam logic [7:0]  CRAFR_MULTI_MAX    = 8'h7b;
    localparam logic [7:0]  CRAFR_MARK_FIRST   = 8'hff;
    localparam logic [10:0] CRAFR_QUERY_OFS    = 11'h001;
    localparam logic [10:0] CRAFR_RESP_OFS     = 11'h002;
    localparam logic [3:0]  CRAFR_SINGLE_DLC   = 4'h5;
    localparam logic [3:0]  CRAFR_MULTI_DLC    = 4'h8;
    localparam logic [3:0]  CRAFR_QUERY_DLC    = 4'h2;
    localparam logic [3:0]  CRAFR_ERR_DLC      = 4'h3;
    localparam int          CRAFR_SLOTS        = 62;
    localparam logic [7:0]  CRAFR_E_BAD_REG    = 8'h02;
    localparam logic [7:0]  CRAFR_E_BAD_DATA   = 8'h03;
    localparam logic [7:0]  CRAFR_E_INCOMPLETE = 8'h04;
    localparam time         CRAFR_CLK_PERIOD_NS = 5;
    localparam int          CRAFR_TIMEOUT_US   = 100000;
    localparam int          CRAFR_TIMEOUT_CYC  = CRAFR_TIMEOUT_US * 1000 / 5;

    typedef struct packed {
        logic        valid;
        logic [10:0] id;
        logic [3:0]  dlc;
        logic [63:0] data;
    } crafr_frame_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] reg_num;
        logic [15:0] value;
    } crafr_wr_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] reg_num;
    } crafr_rd_t;
endpackage : crafr_pkg

// ---- verilog/crafr_asm.sv ----
// Fragment reassembly store for multi-register writes
`timescale 1ns/100ps
module crafr_asm
    import crafr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clear,
    input  wire logic        put,
    input  wire logic [5:0]  slot,
    input  wire logic [31:0] put_data,
    input  wire logic [5:0]  rd_slot,
    output logic [31:0]      rd_data,
    output logic [63:0]      got
);
    logic [31:0] mem [CRAFR_SLOTS];

    // Data is placed by its marker slot, so arrival order is irrelevant [R12]
    always_ff @(posedge clk) begin
        if (put) begin
            mem[slot] <= put_data;
        end
    end

    assign rd_data = mem[rd_slot];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            got <= '0;
        end else if (clear) begin
            got <= '0;
        end else if (put) begin
            got[slot] <= 1'b1;
        end
    end
endmodule : crafr_asm

// ---- verilog/crafr_top.sv ----
// CAN frame to register access interpreter
// Contract
// R1: Frames on the base identifier are object writes.
// R2: Queries arrive on base plus one; all responses go on base plus two.
// R3: Query and response identifiers follow base identifier changes.
// R4: Broadcast identifier accepts writes only, never queries; a broadcast identifier equal to base plus one has its frames taken as queries.
// R5: Bytes 0-1 hold register number, valid from 0 to 65534.
// R6: Writes on base or broadcast give start register, count, parameters.
// R7: Single write: count exactly one, 16-bit value in bytes 3-4.
// R8: Multi write: count 2 to 123, marker byte 3, data bytes 4-7.
// R9: Every fragment carries the object's start register, not incremented.
// R10: Host sets count to number of 16-bit registers in object.
// R11: First fragment marker 0xff, each following fragment decrements one.
// R12: Fragment data is placed by marker value, not arrival order.
// R13: Each fragment carries four data bytes, unused ones zero.
// R14: Full-length or shortened transfers are both accepted.
// R15: Unsolicited error responses are sent on communication or access errors.
// R16: Error response holds 65535 in bytes 0-1, code in byte 2.
// R17: A query holds only the start register in two bytes.
// R18: Commit only after all fragments; incomplete transfer reports error.
`timescale 1ns/100ps
module crafr_top
    import crafr_pkg::*;
#(
    parameter int TIMEOUT_CYC = CRAFR_TIMEOUT_CYC
)
(
    input  wire logic                 CLOCK,
    input  wire logic                 RESET_N,
    input  wire logic [10:0]          BASE_ID,
    input  wire logic [10:0]          BCAST_ID,
    input  wire crafr_pkg::crafr_frame_t RX_FRAME,
    input  wire logic                 TX_READY,
    output crafr_pkg::crafr_frame_t   TX_FRAME,
    output crafr_pkg::crafr_wr_t      REG_WRITE,
    output crafr_pkg::crafr_rd_t      REG_QUERY
);
    import crafr_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_COLLECT, S_COMMIT} crafr_state_t;

    typedef struct packed {
        crafr_state_t  st;
        logic [15:0]   start_reg;
        logic [7:0]    count;
        logic [5:0]    nfrag;
        logic [5:0]    idx;
        logic          half;
        logic [31:0]   tmo;
        crafr_frame_t  tx;
        crafr_wr_t     wr;
        crafr_rd_t     rd;
    } crafr_regs_t;

    crafr_regs_t s_r, s_nxt;

    logic        is_base, is_bcast, is_query, multi_ok, single_ok, reg_ok, frag_in;
    logic        asm_put, asm_clear;
    logic [5:0]  frag_slot;
    logic [31:0] asm_rd;
    logic [63:0] asm_got;
    logic [15:0] rx_reg;
    logic [7:0]  rx_cnt, rx_mark;
    logic [7:0]  err_code;
    logic        err_evt;

    assign rx_reg    = RX_FRAME.data[63:48];
    assign rx_cnt    = RX_FRAME.data[47:40];
    assign rx_mark   = RX_FRAME.data[39:32];
    assign is_base   = RX_FRAME.valid && RX_FRAME.id == BASE_ID;                      // [R1]
    assign is_bcast  = RX_FRAME.valid && RX_FRAME.id == BCAST_ID && !is_base;         // [R4]
    assign is_query  = RX_FRAME.valid && RX_FRAME.id == BASE_ID + CRAFR_QUERY_OFS;    // [R2] [R3]
    assign reg_ok    = rx_reg <= CRAFR_MAX_REG;                                       // [R5]
    assign single_ok = rx_cnt == CRAFR_SINGLE_CNT && RX_FRAME.dlc >= CRAFR_SINGLE_DLC; // [R7]
    assign multi_ok  = rx_cnt >= CRAFR_MULTI_MIN && rx_cnt <= CRAFR_MULTI_MAX
                       && RX_FRAME.dlc == CRAFR_MULTI_DLC;                            // [R8] [R13]
    assign frag_slot = 6'(CRAFR_MARK_FIRST - rx_mark);                                // [R11]
    assign frag_in   = (is_base || is_bcast) && reg_ok && multi_ok;                   // [R6]

    crafr_asm u_asm (
        .clk      (CLOCK),
        .rst_n    (RESET_N),
        .clear    (asm_clear),
        .put      (asm_put),
        .slot     (frag_slot),
        .put_data (RX_FRAME.data[31:0]),
        .rd_slot  (s_r.idx),
        .rd_data  (asm_rd),
        .got      (asm_got)
    );

    always_comb begin
        s_nxt     = s_r;
        asm_put   = 1'b0;
        asm_clear = 1'b0;
        err_evt   = 1'b0;
        err_code  = 8'h00;
        s_nxt.wr.valid = 1'b0;
        s_nxt.rd.valid = 1'b0;
        if (TX_READY) begin
            s_nxt.tx.valid = 1'b0;
        end
        if (s_r.st == S_COLLECT) begin
            s_nxt.tmo = s_r.tmo + 32'h1;
        end
        if (is_query && !is_base) begin
            // Only the start register is meaningful in a query [R17]
            if (reg_ok && RX_FRAME.dlc >= CRAFR_QUERY_DLC) begin
                s_nxt.rd.valid   = 1'b1;
                s_nxt.rd.reg_num = rx_reg;
            end else begin
                err_evt  = 1'b1;
                err_code = CRAFR_E_BAD_REG;
            end
        end else if ((is_base || is_bcast) && !reg_ok) begin
            err_evt  = 1'b1;
            err_code = CRAFR_E_BAD_REG;
        end else if ((is_base || is_bcast) && single_ok) begin
            s_nxt.wr.valid   = 1'b1;                                                  // [R7]
            s_nxt.wr.reg_num = rx_reg;
            s_nxt.wr.value   = RX_FRAME.data[39:24];
        end else if (frag_in && s_r.st != S_COMMIT) begin
            // Fragments carry the listed start register; a mismatch restarts [R9]
            if (s_r.st == S_IDLE || rx_reg != s_r.start_reg || rx_cnt != s_r.count) begin
                asm_clear       = 1'b1;
                s_nxt.st        = S_COLLECT;
                s_nxt.start_reg = rx_reg;
                s_nxt.count     = rx_cnt;                                             // [R10]
                s_nxt.nfrag     = 6'((rx_cnt + 8'h1) >> 1);                          // [R14]
                if (s_r.st == S_COLLECT) begin
                    err_evt  = 1'b1;
                    err_code = CRAFR_E_INCOMPLETE;
                end
            end
            s_nxt.tmo = '0;
            if ({2'b00, frag_slot} < 8'((rx_cnt + 8'h1) >> 1)) begin
                asm_put = !asm_clear;
            end else begin
                err_evt  = 1'b1;
                err_code = CRAFR_E_BAD_DATA;
            end
        end else if ((is_base || is_bcast) && !frag_in) begin
            // Other frames on a write identifier report bad data; fragments that land during the commit burst are dropped silently
            err_evt  = 1'b1;
            err_code = CRAFR_E_BAD_DATA;
        end
        // A fresh start frame cannot be stored in the clear cycle; it is dropped and must be sent again
        if (s_r.st == S_COLLECT && !asm_clear) begin
            if (&(asm_got | ~((64'h1 << s_r.nfrag) - 64'h1))) begin
                s_nxt.st   = S_COMMIT;                                                // [R18]
                s_nxt.idx  = '0;
                s_nxt.half = 1'b0;
            end else if (s_r.tmo >= 32'(TIMEOUT_CYC)) begin
                s_nxt.st = S_IDLE;                                                    // [R18]
                err_evt  = 1'b1;
                err_code = CRAFR_E_INCOMPLETE;
            end
        end
        if (s_r.st == S_COMMIT) begin
            s_nxt.wr.valid   = 1'b1;
            s_nxt.wr.reg_num = s_r.start_reg + {s_r.idx, s_r.half} - 16'h0;
            s_nxt.wr.value   = s_r.half ? asm_rd[15:0] : asm_rd[31:16];
            s_nxt.half       = !s_r.half;
            if (s_r.half) begin
                s_nxt.idx = s_r.idx + 6'h1;
            end
            if (8'({s_r.idx, s_r.half}) + 8'h1 >= s_r.count) begin
                s_nxt.st = S_IDLE;
            end
        end
        if (err_evt) begin
            // Unsolicited error report on the response identifier [R15] [R16]
            s_nxt.tx.valid = 1'b1;
            s_nxt.tx.id    = BASE_ID + CRAFR_RESP_OFS;                                // [R2]
            s_nxt.tx.dlc   = CRAFR_ERR_DLC;
            s_nxt.tx.data  = {CRAFR_ERR_REG, err_code, 40'h0};
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign TX_FRAME  = s_r.tx;
    assign REG_WRITE = s_r.wr;
    assign REG_QUERY = s_r.rd;

    chk_err_reg_val: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        $rose(TX_FRAME.valid) |-> TX_FRAME.data[63:48] == 16'hffff)      // [R16]
        else $error("error response lacks 65535 marker");
    chk_resp_id_base: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        $rose(TX_FRAME.valid) |-> TX_FRAME.id == $past(BASE_ID) + 11'h002) // [R2]
        else $error("response not on base plus two");
    chk_bcast_no_query: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        RX_FRAME.valid && RX_FRAME.id == BCAST_ID && RX_FRAME.id != BASE_ID + 11'h001
        |=> !REG_QUERY.valid)                                              // [R4]
        else $error("broadcast frame produced a query");
    chk_single_write: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        RX_FRAME.valid && RX_FRAME.id == BASE_ID && RX_FRAME.data[47:40] == 8'h01
        && RX_FRAME.dlc >= 4'h5 && RX_FRAME.data[63:48] != 16'hffff
        |=> REG_WRITE.valid && REG_WRITE.value == $past(RX_FRAME.data[39:24])) // [R7]
        else $error("single write not forwarded");
    chk_query_fwd: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        REG_QUERY.valid |-> $past(RX_FRAME.id) == $past(BASE_ID) + 11'h001
        && REG_QUERY.reg_num != 16'hffff)                                  // [R3] [R5]
        else $error("query forwarded from wrong identifier");
    chk_bad_reg_err: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        RX_FRAME.valid && RX_FRAME.id == BASE_ID && RX_FRAME.data[63:48] == 16'hffff
        |=> TX_FRAME.valid && TX_FRAME.data[47:40] == 8'h02)               // [R15]
        else $error("register 65535 not reported");
    chk_commit_done: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        s_r.st == S_COMMIT |-> ##[1:123] s_r.st == S_IDLE)                // [R18]
        else $error("commit phase overran count");
    chk_multi_no_early: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        s_r.st == S_COLLECT |-> !REG_WRITE.valid || $past(RX_FRAME.data[47:40]) == 8'h01) // [R18]
        else $error("multi write committed early");
endmodule : crafr_top

// ---- dv/crafr_host.sv ----
// Behavioural CAN host: frame source and paced transmit sink
`timescale 1ns/100ps
module crafr_host
(
    input  wire logic               clk,
    input  wire logic               stall,
    output crafr_pkg::crafr_frame_t rx_frame,
    output logic                    tx_ready
);
    import crafr_pkg::*;
    initial begin
        rx_frame = '0;
        tx_ready = 1'b0;
    end
    // Ready drops at random so the transmitter has to hold its frame
    always @(posedge clk) tx_ready <= #1 ~stall;
    task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
        @(posedge clk);
        #1;
        rx_frame = {1'b1, id, dlc, data};
        @(posedge clk);
        #1;
        // Idle bus shows the inverse, never a stale copy
        rx_frame = {1'b0, ~id, ~dlc, ~data};
    endtask : send
endmodule : crafr_host

// ---- dv/tb_can_register_access_framer.sv ----
// Self-checking bench for the CAN register access framer
`timescale 1ns/100ps
module tb_can_register_access_framer;
    import crafr_pkg::*;
    localparam int TOUT = 200;
    logic         clock, reset_n, stall, tx_ready;
    logic [10:0]  base_id, bcast_id;
    logic [31:0]  rs;
    crafr_frame_t rx_frame, tx_frame, tx_prev;
    crafr_wr_t    reg_write;
    crafr_rd_t    reg_query;
    crafr_wr_t    wq[$];
    crafr_rd_t    qq[$];
    crafr_frame_t tq[$];
    int           bad_count = 0;
    int           tests_run = 0;
    crafr_top #(.TIMEOUT_CYC(TOUT)) dut (.CLOCK(clock), .RESET_N(reset_n), .BASE_ID(base_id),
        .BCAST_ID(bcast_id), .RX_FRAME(rx_frame), .TX_READY(tx_ready), .TX_FRAME(tx_frame),
        .REG_WRITE(reg_write), .REG_QUERY(reg_query));
    crafr_host host (.clk(clock), .stall(stall), .rx_frame(rx_frame), .tx_ready(tx_ready));
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic finish_test();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle
    // Outputs are sampled mid-cycle, clear of the launching edge
    always @(negedge clock) begin
        if (reg_write.valid === 1'b1) wq.push_back(reg_write);
        if (reg_query.valid === 1'b1) qq.push_back(reg_query);
        if (tx_prev.valid === 1'b1) check("tx held", tx_prev, tx_frame);
        tx_prev = (tx_frame.valid === 1'b1 && tx_ready !== 1'b1) ? tx_frame : '0;
        if (tx_frame.valid === 1'b1 && tx_ready === 1'b1) tq.push_back(tx_frame);
    end
    always @(posedge clock) stall <= #1 ((rnd() & 32'h3) == 32'h0);
    task automatic expect_err(input logic [7:0] code);
        crafr_frame_t f = '0;
        for (int i = 0; i < 30 && tq.size() == 0; i++) @(posedge clock);
        idle(2);
        check("error count", 1, tq.size());
        if (tq.size() > 0) f = tq.pop_front();
        check("error frame", {base_id + CRAFR_RESP_OFS, CRAFR_ERR_DLC, CRAFR_ERR_REG, code},
            {f.id, f.dlc, f.data[63:40]});
        check("no write", 0, wq.size());
        tq.delete();
    endtask : expect_err
    task automatic err_case(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d,
                            input logic [7:0] code);
        host.send(id, dlc, d);
        expect_err(code);
    endtask : err_case
    task automatic expect_wr(input logic [15:0] r0, input logic [15:0] v[$]);
        for (int i = 0; i < 300 && wq.size() < v.size(); i++) @(posedge clock);
        idle(2);
        check("write count", v.size(), wq.size());
        foreach (v[i]) if (i < wq.size())
            check("write", {r0 + 16'(i), v[i]}, {wq[i].reg_num, wq[i].value});
        wq.delete();
    endtask : expect_wr
    task automatic expect_q(input logic [15:0] r, input int n);
        idle(3);
        check("query count", n, qq.size());
        if (n > 0 && qq.size() > 0) check("query reg", r, qq[0].reg_num);
        qq.delete();
    endtask : expect_q
    task automatic send_m(input logic [15:0] r0, input logic [7:0] n, input int s,
                          input logic [31:0] d);
        host.send(base_id, CRAFR_MULTI_DLC, {r0, n, CRAFR_MARK_FIRST - 8'(s), d});
    endtask : send_m
    task automatic multi(input logic [15:0] r0, input logic [7:0] n);
        logic [31:0] d[CRAFR_SLOTS];
        logic [15:0] v[$];
        int nf, off;
        nf = (n + 1) / 2;
        off = int'(rnd() % nf);
        for (int k = 0; k < nf; k++) d[k] = rnd();
        if (n[0]) d[nf - 1][15:0] = 16'h0000;
        for (int k = 0; k < n; k++) v.push_back(k[0] ? d[k / 2][15:0] : d[k / 2][31:16]);
        // The opening fragment only starts collection and is sent again below
        send_m(r0, n, 0, d[0]);
        for (int k = 0; k < nf; k++) send_m(r0, n, (k + off) % nf, d[(k + off) % nf]);
        expect_wr(r0, v);
    endtask : multi
    task automatic drain();
        idle(TOUT + 40);
        tq.delete();
        wq.delete();
    endtask : drain
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (30000) @(posedge clock);
        bad_count++;
        finish_test();
    end
    initial begin
        logic [15:0] r, v;
        logic [10:0] old;
        rs = 32'hbdee0c23;
        reset_n = 1'b0;
        stall = 1'b0;
        base_id = 11'h120;
        bcast_id = 11'h400;
        tx_prev = '0;
        idle(4);
        reset_n = 1'b1;
        check("reset", 0, {tx_frame.valid, reg_write.valid, reg_query.valid});
        for (int i = 0; i < 10; i++) begin
            r = (i == 0) ? 16'h0000 : (i == 1) ? CRAFR_MAX_REG : 16'(rnd() % 32'hffff);
            v = 16'(rnd());
            host.send(i[0] ? bcast_id : base_id, CRAFR_SINGLE_DLC,
                {r, CRAFR_SINGLE_CNT, v, 24'h0});
            expect_wr(r, '{v});
            host.send(base_id + CRAFR_QUERY_OFS, CRAFR_QUERY_DLC, {r, 48'h0});
            expect_q(r, 1);
        end
        old = base_id;
        base_id = 11'h200 + 11'(rnd() & 32'hff);
        host.send(old + CRAFR_QUERY_OFS, CRAFR_QUERY_DLC, 64'h0);
        expect_q(16'h0, 0);
        host.send(base_id + CRAFR_QUERY_OFS, CRAFR_QUERY_DLC, {r, 48'h0});
        expect_q(r, 1);
        host.send(bcast_id + CRAFR_QUERY_OFS, CRAFR_QUERY_DLC, {r, 48'h0});
        expect_q(r, 0);
        err_case(base_id + CRAFR_QUERY_OFS, CRAFR_QUERY_DLC, {CRAFR_ERR_REG, 48'h0},
            CRAFR_E_BAD_REG);
        err_case(base_id + CRAFR_QUERY_OFS, 4'h1, 64'h0, CRAFR_E_BAD_REG);
        err_case(bcast_id, CRAFR_SINGLE_DLC, {CRAFR_ERR_REG, 8'h01, 40'h0}, CRAFR_E_BAD_REG);
        err_case(base_id, CRAFR_SINGLE_DLC, {16'h0010, 48'h0}, CRAFR_E_BAD_DATA);
        err_case(base_id, CRAFR_MULTI_DLC, {16'h0010, CRAFR_MULTI_MAX + 8'h01, 40'hff00000000},
            CRAFR_E_BAD_DATA);
        err_case(base_id, CRAFR_SINGLE_DLC, {16'h0010, CRAFR_MULTI_MIN, 40'hff00000000},
            CRAFR_E_BAD_DATA);
        multi(16'h0100, CRAFR_MULTI_MIN);
        multi(16'h0200, 8'd5);
        multi(16'h0300, 8'd20);
        multi(16'h0400, 8'd8);
        multi(16'h1000, CRAFR_MULTI_MAX);
        send_m(16'h0500, 8'd2, 0, 32'h0);
        send_m(16'h0500, 8'd2, 1, 32'h0);
        expect_err(CRAFR_E_BAD_DATA);
        drain();
        send_m(16'h0600, 8'd4, 0, 32'h0);
        send_m(16'h0600, 8'd4, 0, 32'h0);
        send_m(16'h0601, 8'd4, 1, 32'h0);
        expect_err(CRAFR_E_INCOMPLETE);
        drain();
        send_m(16'h0700, 8'd4, 0, 32'h0);
        send_m(16'h0700, 8'd4, 0, 32'h0);
        idle(TOUT);
        expect_err(CRAFR_E_INCOMPLETE);
        idle(10);
        finish_test();
    end
endmodule : tb_can_register_access_framer
